// File: design/reset_mode_params.svh
`ifndef RESET_MODE_PARAMS_SVH
`define RESET_MODE_PARAMS_SVH
`define ADDR_SOFT_RESET 7'h00
`define ADDR_ADC_LOW_POWER 7'h07
`define ADDR_TEST_MODE 7'h0d
`define ADDR_RX_BIAS 7'h13
`define SOFT_RESET_BIT 5
`define ADC_LOW_POWER_BIT 4
`define ANALOG_LOOP_BIT 7
`define DIGITAL_LOOP_BIT 6
`define RX_PORT_HIZ_BIT 5
`define COARSE_MSB 7
`define COARSE_LSB 5
`define SAMPLED_MSB 4
`define SAMPLED_LSB 3
`define CONV_MSB 2
`define CONV_LSB 0
`define CONV_LOW_POWER_CODE 3'h3
`define RX_BIAS_RESET 8'h00
`define TEST_MODE_RESET 8'h00
`define CTRL_DEF_HALF 8'h00
`define CTRL_DEF_FULL 8'h00
`define LOWPWR_DEF_HALF 8'h00
`define LOWPWR_DEF_FULL_CFG0 8'h00
`define LOWPWR_DEF_FULL_CFG1 8'h10
`define READ_UNMAPPED 8'h00
`define ADDR_BITS 5'd8
`define FRAME_BITS 5'd16
`define PIN_SYNC_RESET 6'h0c
`define SETTLE_CYC 3'h4
`define CLK_PERIOD_NS 20
`define RST_MIN_NS 50
`define RST_MIN_CYC ((`RST_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// File: design/reset_mode_pkg.sv
package reset_mode_pkg;
  typedef struct packed {
    logic [2:0] coarse;
    logic [1:0] sampled;
    logic [2:0] converter;
  } rx_bias_t;
  typedef struct packed {
    logic sclk;
    logic sdi;
    logic sel_n;
    logic reset_n;
    logic mode;
    logic cfg;
  } pin_bits_t;
  typedef enum logic [1:0] {
    SP_IDLE = 2'b00,
    SP_ADDR = 2'b01,
    SP_DATA = 2'b10,
    SP_DONE = 2'b11
  } serial_state_t;
endpackage

// File: design/reset_mode_loopback_control.sv
`include "reset_mode_params.svh"
`timescale 1ns/1ns
`default_nettype none
module reset_mode_loopback_control (
  input  wire logic                       ref_clk,
  input  wire logic                       rst_n,
  input  wire logic                       hw_reset_pin_n,
  input  wire logic                       mode_strap,
  input  wire logic                       config_strap,
  input  wire logic                       serial_port_select_n,
  input  wire logic                       serial_clk,
  input  wire logic                       serial_data_in,
  output logic                            serial_data_out,
  output logic                            serial_data_oe_n,
  input  wire logic [5:0]                 tx_port_data,
  input  wire logic [9:0]                 tx_sample,
  input  wire logic [9:0]                 adc_sample,
  input  wire logic [5:0]                 rx_port_word,
  output logic      [9:0]                 interp_in,
  output logic      [5:0]                 rx_port_out,
  output logic                            rx_port_oe_n,
  output logic                            full_duplex,
  output logic                            cal_start,
  output reset_mode_pkg::rx_bias_t        rx_bias
);

  logic [5:0]                  pin_raw;
  logic [5:0]                  s1_q;
  logic [5:0]                  s2_q;
  logic [5:0]                  s3_q;
  logic [5:0]                  lvl_q;
  logic [5:0]                  lvl_d;
  reset_mode_pkg::pin_bits_t   pin_lvl;
  logic                        sclk_prev_q;
  logic                        hw_prev_q;
  logic [2:0]                  settle_q;
  logic [2:0]                  settle_d;
  logic                        any_rst;
  logic                        rise;
  logic [7:0]                  ctrl_def;
  logic [7:0]                  lp_def;
  reset_mode_pkg::serial_state_t st_q;
  reset_mode_pkg::serial_state_t st_d;
  logic [4:0]                  cnt_q;
  logic [4:0]                  cnt_d;
  logic [7:0]                  sh_q;
  logic [7:0]                  sh_d;
  logic [7:0]                  cmd_q;
  logic [7:0]                  cmd_d;
  logic [7:0]                  rd_q;
  logic [7:0]                  rd_d;
  logic [7:0]                  full_byte;
  logic                        wr_en;
  logic [7:0]                  read_val;
  logic [7:0]                  ctrl_q;
  logic [7:0]                  ctrl_d;
  logic [7:0]                  lowpwr_q;
  logic [7:0]                  lowpwr_d;
  logic [7:0]                  test_q;
  logic [7:0]                  test_d;
  logic [7:0]                  bias_q;
  logic [7:0]                  bias_d;
  logic                        soft_q;
  logic                        soft_d;
  logic                        fd_q;
  logic                        fd_d;
  logic                        cal_q;
  logic                        cal_d;
  reset_mode_pkg::rx_bias_t    bias_out_q;
  reset_mode_pkg::rx_bias_t    bias_out_d;
  logic [9:0]                  interp_q;
  logic [9:0]                  interp_d;
  logic [5:0]                  rx_out_q;
  logic [5:0]                  rx_out_d;

  assign pin_raw = {serial_clk, serial_data_in, serial_port_select_n,
                    hw_reset_pin_n, mode_strap, config_strap};
  assign pin_lvl = lvl_q;

  // pin synchronisers
  // a level counts once stages two and three agree; a legal pulse spans
  // at least three edges so it is never filtered out
  genvar g;
  for (g = 0; g < 6; g++)
  begin : g_sync
    always_comb
    begin
      lvl_d[g] = (s2_q[g] == s3_q[g]) ? s3_q[g] : lvl_q[g];
    end
  end

  always_ff @(posedge ref_clk)
  begin
    s1_q <= pin_raw;
    s2_q <= s1_q;
    s3_q <= s2_q;
    lvl_q <= rst_n ? lvl_d : `PIN_SYNC_RESET;
  end

  // settle count keeps reset on until the strap levels are through the
  // synchronisers, otherwise the reset values would be taken as straps
  always_comb
  begin
    settle_d = (settle_q != 3'h0) ? settle_q - 3'h1 : settle_q;
  end

  assign any_rst = !rst_n || !pin_lvl.reset_n || soft_q || (settle_q != 3'h0);
  assign rise = pin_lvl.sclk && !sclk_prev_q;

  always_comb
  begin
    case ({pin_lvl.mode, pin_lvl.cfg})
      2'b00, 2'b01:
      begin
        ctrl_def = `CTRL_DEF_HALF;
        lp_def = `LOWPWR_DEF_HALF;
      end
      2'b10:
      begin
        ctrl_def = `CTRL_DEF_FULL;
        lp_def = `LOWPWR_DEF_FULL_CFG0;
      end
      default:
      begin
        ctrl_def = `CTRL_DEF_FULL;
        lp_def = `LOWPWR_DEF_FULL_CFG1;
      end
    endcase
  end

  always_comb
  begin
    case (full_byte[6:0])
      `ADDR_SOFT_RESET: read_val = ctrl_q;
      `ADDR_ADC_LOW_POWER: read_val = lowpwr_q;
      `ADDR_TEST_MODE: read_val = test_q;
      `ADDR_RX_BIAS: read_val = bias_q;
      default: read_val = `READ_UNMAPPED;
    endcase
  end

  assign full_byte = {sh_q[6:0], pin_lvl.sdi};

  // serial engine idles while select high
  always_comb
  begin
    st_d = st_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    cmd_d = cmd_q;
    rd_d = rd_q;
    wr_en = 1'b0;
    if (pin_lvl.sel_n)
    begin
      st_d = reset_mode_pkg::SP_IDLE;
      cnt_d = 5'h0;
    end
    else
    begin
      case (st_q)
        reset_mode_pkg::SP_IDLE:
        begin
          st_d = reset_mode_pkg::SP_ADDR;
          cnt_d = 5'h0;
        end
        reset_mode_pkg::SP_ADDR:
        begin
          if (rise)
          begin
            sh_d = full_byte;
            cnt_d = cnt_q + 5'h1;
            if (cnt_q == `ADDR_BITS - 5'h1)
            begin
              st_d = reset_mode_pkg::SP_DATA;
              cmd_d = full_byte;
              rd_d = read_val;
            end
          end
        end
        reset_mode_pkg::SP_DATA:
        begin
          if (rise)
          begin
            sh_d = full_byte;
            cnt_d = cnt_q + 5'h1;
            rd_d = {rd_q[6:0], 1'b0};
            if (cnt_q == `FRAME_BITS - 5'h1)
            begin
              st_d = reset_mode_pkg::SP_DONE;
              wr_en = !cmd_q[7];
            end
          end
        end
        default:
        begin
          st_d = reset_mode_pkg::SP_DONE;
        end
      endcase
    end
  end

  always_comb
  begin
    ctrl_d = ctrl_q;
    lowpwr_d = lowpwr_q;
    test_d = test_q;
    bias_d = bias_q;
    soft_d = 1'b0;
    if (any_rst)
    begin
      ctrl_d = ctrl_def;
      lowpwr_d = lp_def;
      test_d = `TEST_MODE_RESET;
      bias_d = `RX_BIAS_RESET;
    end
    else if (wr_en)
    begin
      case (cmd_q[6:0])
        `ADDR_SOFT_RESET:
        begin
          ctrl_d = full_byte & ~(8'h01 << `SOFT_RESET_BIT);
          soft_d = full_byte[`SOFT_RESET_BIT];
        end
        `ADDR_ADC_LOW_POWER: lowpwr_d = full_byte;
        `ADDR_TEST_MODE: test_d = full_byte;
        `ADDR_RX_BIAS: bias_d = full_byte;
        default: ctrl_d = ctrl_q;
      endcase
    end
  end

  always_comb
  begin
    fd_d = any_rst ? pin_lvl.mode : fd_q;
    cal_d = rst_n && pin_lvl.reset_n && !hw_prev_q;
  end

  always_comb
  begin
    bias_out_d.coarse = bias_q[`COARSE_MSB:`COARSE_LSB];
    bias_out_d.sampled = bias_q[`SAMPLED_MSB:`SAMPLED_LSB];
    bias_out_d.converter = lowpwr_q[`ADC_LOW_POWER_BIT] ? `CONV_LOW_POWER_CODE
                                                        : bias_q[`CONV_MSB:`CONV_LSB];
  end

  always_comb
  begin
    interp_d = test_q[`ANALOG_LOOP_BIT] ? adc_sample : tx_sample;
    rx_out_d = (test_q[`DIGITAL_LOOP_BIT] && fd_q) ? tx_port_data : rx_port_word;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      sclk_prev_q <= 1'b0;
      hw_prev_q <= 1'b1;
      settle_q <= `SETTLE_CYC;
      cal_q <= 1'b0;
      bias_out_q <= '0;
      rx_out_q <= 6'h00;
    end
    else
    begin
      sclk_prev_q <= pin_lvl.sclk;
      hw_prev_q <= pin_lvl.reset_n;
      settle_q <= settle_d;
      cal_q <= cal_d;
      bias_out_q <= bias_out_d;
      rx_out_q <= rx_out_d;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (any_rst)
    begin
      st_q <= reset_mode_pkg::SP_IDLE;
      cnt_q <= 5'h0;
      sh_q <= 8'h00;
      cmd_q <= 8'h00;
      rd_q <= 8'h00;
    end
    else
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      cmd_q <= cmd_d;
      rd_q <= rd_d;
    end
    ctrl_q <= ctrl_d;
    lowpwr_q <= lowpwr_d;
    test_q <= test_d;
    bias_q <= bias_d;
    soft_q <= rst_n && soft_d;
    fd_q <= fd_d;
  end

  // transmit path never reset
  // the interpolation input keeps running through any reset so stored
  // filter history is not disturbed
  always_ff @(posedge ref_clk)
  begin
    interp_q <= interp_d;
  end

  assign interp_in = interp_q;
  assign rx_port_out = rx_out_q;
  assign rx_port_oe_n = test_q[`RX_PORT_HIZ_BIT];
  assign full_duplex = fd_q;
  assign cal_start = cal_q;
  assign rx_bias = bias_out_q;
  assign serial_data_out = rd_q[7];
  assign serial_data_oe_n = !(st_q == reset_mode_pkg::SP_DATA && cmd_q[7]);

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_soft_write;
    !any_rst && wr_en && cmd_q[6:0] == `ADDR_SOFT_RESET && full_byte[`SOFT_RESET_BIT];
  endsequence

  sequence s_soft_done;
    soft_q ##1 (!soft_q && test_q == `TEST_MODE_RESET && bias_q == `RX_BIAS_RESET);
  endsequence

  a_mode_capture: assert property (any_rst |=> fd_q == $past(pin_lvl.mode))
    else $error("duplex mode not taken from strap");
  a_strap_default: assert property (any_rst |=> lowpwr_q == $past(lp_def))
    else $error("low power default not from straps");
  a_select_idle: assert property (pin_lvl.sel_n |-> !wr_en ##1 st_q == reset_mode_pkg::SP_IDLE)
    else $error("serial write while deselected");
  a_soft_reset: assert property (s_soft_write |=> s_soft_done)
    else $error("soft reset did not restore defaults");
  a_soft_no_cal: assert property (soft_q && pin_lvl.reset_n |-> !cal_start [*3])
    else $error("calibration started by soft reset");
  a_interp_runs: assert property (any_rst && !test_q[`ANALOG_LOOP_BIT]
                                  |=> interp_in == $past(tx_sample))
    else $error("transmit path disturbed by reset");
  a_cal_release: assert property ($rose(pin_lvl.reset_n) |=> cal_start ##1 !cal_start)
    else $error("calibration pulse missing on release");
  a_bias_fields: assert property (##2 rx_bias.coarse == $past(bias_q[`COARSE_MSB:`COARSE_LSB], 1)
                                  && rx_bias.sampled == $past(bias_q[`SAMPLED_MSB:`SAMPLED_LSB], 1))
    else $error("bias fields misplaced");
  a_bias_reset: assert property (!pin_lvl.reset_n |=> bias_q == `RX_BIAS_RESET
                                 ##1 rx_bias == {5'h00, $past(lowpwr_q[`ADC_LOW_POWER_BIT])
                                                 ? `CONV_LOW_POWER_CODE : 3'h0})
    else $error("bias register not cleared");
  a_low_power: assert property (lowpwr_q[`ADC_LOW_POWER_BIT] |=> rx_bias.converter == `CONV_LOW_POWER_CODE)
    else $error("low power bit not mapped to 011");
  a_analog_loop: assert property (test_q[`ANALOG_LOOP_BIT] |=> interp_in == $past(adc_sample))
    else $error("analog loopback not routed");
  a_digital_loop: assert property (test_q[`DIGITAL_LOOP_BIT] && fd_q
                                   |=> rx_port_out == $past(tx_port_data))
    else $error("digital loopback not routed");
  a_rx_hiz: assert property (!any_rst && wr_en && cmd_q[6:0] == `ADDR_TEST_MODE
                             |=> rx_port_oe_n == $past(full_byte[`RX_PORT_HIZ_BIT]))
    else $error("receive port enable wrong");
  a_test_clear: assert property (any_rst |=> test_q == `TEST_MODE_RESET && rx_port_oe_n == 1'b0)
    else $error("test bits survive reset");
  a_self_clear: assert property (soft_q |=> !soft_q && ctrl_q[`SOFT_RESET_BIT] == 1'b0)
    else $error("soft reset bit stuck");

endmodule
`default_nettype wire

// File: tb/host_model.sv
`timescale 1ns/1ns
`default_nettype none
module host_model #(
  parameter int POWER_ON_CYC = 64
) (
  input  wire logic ref_clk,
  input  wire logic serial_data_out,
  input  wire logic serial_data_oe_n,
  output logic      hw_reset_pin_n,
  output logic      serial_port_select_n,
  output logic      serial_clk,
  output logic      serial_data_in
);
  // power-on hold
  // scaled-down hold; the real one would make the run far too long
  initial
  begin
    hw_reset_pin_n       = 1'b0;
    serial_port_select_n = 1'b1;
    serial_clk           = 1'b0;
    serial_data_in       = 1'b0;
    repeat (POWER_ON_CYC) @(negedge ref_clk);
    hw_reset_pin_n = 1'b1;
  end

  task automatic pin_low(input int n);
    hw_reset_pin_n = 1'b0;
    repeat ((n < 3) ? 3 : n) @(negedge ref_clk);
  endtask

  task automatic pin_high();
    hw_reset_pin_n = 1'b1;
  endtask

  // select left high
  // sel low keeps the port deselected while the clock still toggles
  task automatic frame(input logic sel, input logic rd, input logic [6:0] a,
                       input logic [7:0] wd, output logic [7:0] rdat);
    logic [15:0] w;
    w    = {rd, a, wd};
    rdat = 8'h00;
    @(negedge ref_clk);
    serial_port_select_n = !sel;
    repeat (4) @(negedge ref_clk);
    for (int b = 0; b < 16; b++)
    begin
      serial_data_in = w[15-b];
      repeat (6) @(negedge ref_clk);
      serial_clk = 1'b1;
      repeat (8) @(negedge ref_clk);
      if (rd && b >= 7 && b < 15)
        rdat[14-b] = (serial_data_oe_n === 1'b0) ? serial_data_out : 1'bx;
      serial_clk = 1'b0;
    end
    repeat (6) @(negedge ref_clk);
    serial_port_select_n = 1'b1;
    // released line shows the inverse, not a stale value
    serial_data_in = !serial_data_in;
    repeat (8) @(negedge ref_clk);
  endtask
endmodule
`default_nettype wire

// File: tb/tb_top.sv
`include "reset_mode_params.svh"
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic                     ref_clk, rst_n, mode_strap, config_strap;
  logic [5:0]               tx_port_data, rx_port_word, rx_port_out;
  logic [9:0]               tx_sample, adc_sample, interp_in;
  logic                     hw_reset_pin_n, serial_port_select_n, serial_clk, serial_data_in;
  logic                     serial_data_out, serial_data_oe_n, rx_port_oe_n, full_duplex, cal_start;
  reset_mode_pkg::rx_bias_t rx_bias;
  int                       fails, compares, cal_count, base;
  logic [7:0]               rdat;

  reset_mode_loopback_control dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .hw_reset_pin_n(hw_reset_pin_n),
    .mode_strap(mode_strap), .config_strap(config_strap), .serial_port_select_n(serial_port_select_n),
    .serial_clk(serial_clk), .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
    .serial_data_oe_n(serial_data_oe_n), .tx_port_data(tx_port_data), .tx_sample(tx_sample),
    .adc_sample(adc_sample), .rx_port_word(rx_port_word), .interp_in(interp_in), .rx_port_out(rx_port_out),
    .rx_port_oe_n(rx_port_oe_n), .full_duplex(full_duplex), .cal_start(cal_start), .rx_bias(rx_bias));

  host_model host_u (.ref_clk(ref_clk), .serial_data_out(serial_data_out), .serial_data_oe_n(serial_data_oe_n),
    .hw_reset_pin_n(hw_reset_pin_n), .serial_port_select_n(serial_port_select_n), .serial_clk(serial_clk),
    .serial_data_in(serial_data_in));

  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = !ref_clk;
  end

  // one count per launch pulse
  always @(negedge ref_clk)
    if (cal_start === 1'b1)
      cal_count++;

  task automatic wrap_up();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] unused;
    host_u.frame(1'b1, 1'b0, a, d, unused);
  endtask

  task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] got;
    host_u.frame(1'b1, 1'b1, a, 8'h00, got);
    check({8'h00, got}, {8'h00, exp});
  endtask

  // bounded wait; running out counts as a mismatch
  task automatic wait_cal(input int target);
    int k;
    k = 0;
    while (cal_count < target && k < 100)
    begin
      cyc(1);
      k++;
    end
    if (cal_count < target)
    begin
      fails++;
      $display("timeout waiting for calibration launch");
      wrap_up();
    end
  endtask

  initial
  begin
    rst_n = 1'b0;
    mode_strap = 1'b0;
    config_strap = 1'b0;
    tx_sample = 10'h155;
    adc_sample = 10'h2ca;
    tx_port_data = 6'h2d;
    rx_port_word = 6'h12;
    fails = 0;
    compares = 0;
    cal_count = 0;
    cyc(16);
    rst_n = 1'b1;
    wait_cal(1);
    check(16'(cal_count), 16'h0001);
    for (int i = 0; i < 4; i++)
    begin
      cyc(1);
      mode_strap = i[1];
      config_strap = i[0] ^ i[1];
      rst_n = 1'b0;
      cyc(4);
      rst_n = 1'b1;
      cyc(10);
      check({15'h0, full_duplex}, {15'h0, mode_strap});
      rd_chk(`ADDR_ADC_LOW_POWER, !mode_strap ? `LOWPWR_DEF_HALF
             : (config_strap ? `LOWPWR_DEF_FULL_CFG1 : `LOWPWR_DEF_FULL_CFG0));
      rd_chk(`ADDR_RX_BIAS, `RX_BIAS_RESET);
    end
    check(16'(rx_bias), 16'h0000);
    wr(`ADDR_RX_BIAS, 8'hb5);
    check(16'(rx_bias.coarse), 16'h0005);
    check(16'(rx_bias.sampled), 16'h0002);
    check(16'(rx_bias.converter), 16'h0005);
    rd_chk(`ADDR_RX_BIAS, 8'hb5);
    wr(`ADDR_RX_BIAS, 8'h00);
    wr(`ADDR_ADC_LOW_POWER, 8'h10);
    check(16'(rx_bias.converter), 16'(`CONV_LOW_POWER_CODE));
    wr(`ADDR_ADC_LOW_POWER, 8'h00);
    wr(`ADDR_TEST_MODE, 8'h80);
    cyc(2);
    check({6'h0, interp_in}, {6'h0, adc_sample});
    wr(`ADDR_TEST_MODE, 8'h40);
    cyc(2);
    check({10'h0, rx_port_out}, {10'h0, tx_port_data});
    wr(`ADDR_TEST_MODE, 8'h20);
    cyc(2);
    check({15'h0, rx_port_oe_n}, 16'h0001);
    check({10'h0, rx_port_out}, {10'h0, rx_port_word});
    // soft reset with live transmit data flowing
    wr(`ADDR_RX_BIAS, 8'hb5);
    wr(`ADDR_TEST_MODE, 8'h60);
    base = cal_count;
    wr(`ADDR_SOFT_RESET, 8'h20);
    tx_sample = 10'h0f3;
    cyc(2);
    check({6'h0, interp_in}, 16'h00f3);
    cyc(4);
    check(16'(rx_bias), 16'h0000);
    check({15'h0, rx_port_oe_n}, 16'h0000);
    rd_chk(`ADDR_TEST_MODE, `TEST_MODE_RESET);
    rd_chk(`ADDR_SOFT_RESET, 8'h00);
    check(16'(cal_count), 16'(base));
    // hardware pin reset
    wr(`ADDR_RX_BIAS, 8'hb5);
    wr(`ADDR_TEST_MODE, 8'h20);
    base = cal_count;
    host_u.pin_low(6);
    check(16'(rx_bias), 16'h0000);
    check({15'h0, rx_port_oe_n}, 16'h0000);
    tx_sample = 10'h30c;
    cyc(2);
    check({6'h0, interp_in}, 16'h030c);
    check(16'(cal_count), 16'(base));
    host_u.pin_high();
    wait_cal(base + 1);
    check(16'(cal_count), 16'(base + 1));
    cyc(10);
    rd_chk(`ADDR_RX_BIAS, `RX_BIAS_RESET);
    host_u.frame(1'b0, 1'b0, `ADDR_RX_BIAS, 8'hff, rdat);
    rd_chk(`ADDR_RX_BIAS, `RX_BIAS_RESET);
    wr(7'h7f, 8'h5a);
    rd_chk(7'h7f, `READ_UNMAPPED);
    wrap_up();
  end
endmodule
`default_nettype wire
